// ===== logic/uwfc_pkg.sv
// Constants, state enumerations and shared helpers of the UART with flow control.
// Assumes a single 50 MHz system clock and an asynchronous active-low module reset.
// Functional notes
// - Programmable baud divider covers common rates, fastest being 1 Mbps.
// - CTS handshake can be enabled or left off by configuration; RTS is driven in every configuration.
// - RTS is driven OFF whenever incoming data cannot be accepted, including sleep.
// - Frame is 8 data bits, optional even parity, then one stop bit.
// - After reset the frame format is 8N1 until configured otherwise.
// - Data bits go out and come in least significant bit first.
// - CTS is an optional handshake input, RTS an optional handshake output.
package uwfc_pkg;

    localparam int          CLK_HZ      = 50_000_000;
    localparam int          CLK_MHZ     = CLK_HZ / 1_000_000;
    localparam int          BIT_NS_MIN  = 1000;
    localparam int          CNT_W       = 16;
    localparam int          DATA_BITS   = 8;
    localparam int          BUF_DEPTH   = 2;
    localparam logic [15:0] DIV_MIN     = 16'((BIT_NS_MIN * CLK_MHZ) / 1000);
    localparam logic [15:0] DIV_RST     = 16'h01B2;
    localparam logic        PAR_EN_RST  = 1'b0;
    localparam logic        FLOW_EN_RST = 1'b0;

    typedef enum logic [2:0] {
        UWFC_TX_IDLE,
        UWFC_TX_START,
        UWFC_TX_DATA,
        UWFC_TX_PAR,
        UWFC_TX_STOP
    } uwfc_tx_st_t;

    typedef enum logic [2:0] {
        UWFC_RX_IDLE,
        UWFC_RX_START,
        UWFC_RX_DATA,
        UWFC_RX_PAR,
        UWFC_RX_STOP
    } uwfc_rx_st_t;

    // Even parity bit for one data byte
    function automatic logic uwfc_parity8(input logic [7:0] d);
        return ^d;
    endfunction

endpackage

// ===== logic/uwfc_buf2.sv
// Small FIFO between the receiver and the consumer of received bytes.
// Assumes writer and reader share the system clock; depth must be a power of two.
`timescale 1ns/1ps
module uwfc_buf2 #(
    parameter int W     = 8,
    parameter int DEPTH = 2
) (
    // Clock and reset
    input  wire logic           i_clk_sys,
    input  wire logic           i_reset_n,
    // Filling side
    input  wire logic [W-1:0]   i_in_data,
    input  wire logic           i_in_valid,
    output logic                o_in_ready,
    // Draining side
    output logic [W-1:0]        o_out_data,
    output logic                o_out_valid,
    input  wire logic           i_out_ready
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
        $error("uwfc_buf2: DEPTH must be a power of two, at least 2");
    end

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [PW-1:0]           wp;
        logic [PW-1:0]           rp;
        logic [PW:0]             cnt;
    } uwfc_buf_st_t;

    uwfc_buf_st_t s_reg;
    uwfc_buf_st_t s_next;
    logic         push;
    logic         pop;

    assign o_in_ready  = (s_reg.cnt != (PW+1)'(DEPTH));
    assign o_out_valid = (s_reg.cnt != '0);
    assign o_out_data  = s_reg.mem[s_reg.rp];
    assign push        = i_in_valid & o_in_ready;
    assign pop         = o_out_valid & i_out_ready;

    always_comb begin
        s_next = s_reg;
        if (push) begin
            s_next.mem[s_reg.wp] = i_in_data;
            s_next.wp            = s_reg.wp + 1'b1;
        end
        if (pop) begin
            s_next.rp = s_reg.rp + 1'b1;
        end
        if (push && !pop) begin
            s_next.cnt = s_reg.cnt + 1'b1;
        end else if (pop && !push) begin
            s_next.cnt = s_reg.cnt - 1'b1;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

endmodule // uwfc_buf2

// ===== logic/uwfc_uart.sv
// UART transmitter and receiver with optional RTS/CTS handshake and even parity.
// Assumes pins arrive asynchronously; configuration and streams are on i_clk_sys.
`timescale 1ns/1ps
module uwfc_uart (
    // Clock and reset
    input  wire logic               i_clk_sys,
    input  wire logic               i_reset_n,
    // Configuration, taken on i_cfg_wr; i_sleep acts directly
    input  wire logic               i_cfg_wr,
    input  wire logic [15:0]        i_cfg_div,
    input  wire logic               i_cfg_par_en,
    input  wire logic               i_cfg_flow_en,
    input  wire logic               i_sleep,
    // Transmit stream
    input  wire logic [7:0]         i_tx_data,
    input  wire logic               i_tx_valid,
    output logic                    o_tx_ready,
    output logic                    o_tx_busy,
    // Receive stream
    output logic [7:0]              o_rx_data,
    output logic                    o_rx_valid,
    input  wire logic               i_rx_ready,
    output logic                    o_rx_par_err,
    output logic                    o_rx_frm_err,
    output logic                    o_rx_overrun,
    // Serial pins
    output logic                    o_txd,
    input  wire logic               i_rxd,
    output logic                    o_rts_n,
    input  wire logic               i_cts_n
);
    import uwfc_pkg::*;

    if (DIV_MIN < 16'h0004) begin : g_chk
        $error("uwfc_uart: clock too slow for the fastest baud rate");
    end

    typedef struct packed {
        logic [15:0]  cfg_div;
        logic         cfg_par;
        logic         cfg_flow;
        logic         cfg_seen;
        logic         cts_s1;
        logic         cts_s2;
        logic         rxd_s1;
        logic         rxd_s2;
        uwfc_tx_st_t  tx_st;
        logic [15:0]  tx_cnt;
        logic [2:0]   tx_bit;
        logic [7:0]   tx_sh;
        logic         tx_par;
        logic         txd;
        uwfc_rx_st_t  rx_st;
        logic [15:0]  rx_cnt;
        logic [2:0]   rx_bit;
        logic [7:0]   rx_sh;
        logic         rx_push;
        logic [7:0]   rx_word;
        logic         par_err;
        logic         frm_err;
        logic         ovr;
        logic         rts_n;
    } uwfc_uart_st_t;

    uwfc_uart_st_t s_reg;
    uwfc_uart_st_t s_next;
    logic          buf_in_ready;
    logic          tx_ready;

    // CTS high means the peer is not ready
    assign tx_ready = (s_reg.tx_st == UWFC_TX_IDLE) && !(s_reg.cfg_flow && s_reg.cts_s2);

    always_comb begin
        s_next         = s_reg;
        s_next.cts_s1  = i_cts_n;
        s_next.cts_s2  = s_reg.cts_s1;
        s_next.rxd_s1  = i_rxd;
        s_next.rxd_s2  = s_reg.rxd_s1;
        s_next.rx_push = 1'b0;
        s_next.par_err = 1'b0;
        s_next.frm_err = 1'b0;
        // Push was a single-cycle offer; a full buffer drops it
        s_next.ovr     = s_reg.rx_push & ~buf_in_ready;
        s_next.rts_n   = ~(buf_in_ready & ~i_sleep);

        if (i_cfg_wr) begin
            // Divisors below the 1 Mbps figure are raised to it
            s_next.cfg_div  = (i_cfg_div < DIV_MIN) ? DIV_MIN : i_cfg_div;
            s_next.cfg_par  = i_cfg_par_en;
            s_next.cfg_flow = i_cfg_flow_en;
            s_next.cfg_seen = 1'b1;
        end

        // Transmitter
        case (s_reg.tx_st)
            UWFC_TX_IDLE: begin
                if (i_tx_valid && tx_ready) begin
                    s_next.tx_st  = UWFC_TX_START;
                    s_next.tx_sh  = i_tx_data;
                    s_next.tx_par = uwfc_parity8(i_tx_data);
                    s_next.tx_cnt = s_reg.cfg_div - 16'h0001;
                    s_next.tx_bit = 3'h0;
                    s_next.txd    = 1'b0;
                end
            end
            default: begin
                if (s_reg.tx_cnt != 16'h0000) begin
                    s_next.tx_cnt = s_reg.tx_cnt - 16'h0001;
                end else begin
                    s_next.tx_cnt = s_reg.cfg_div - 16'h0001;
                    case (s_reg.tx_st)
                        UWFC_TX_START: begin
                            s_next.tx_st = UWFC_TX_DATA;
                            s_next.txd   = s_reg.tx_sh[0];
                        end
                        UWFC_TX_DATA: begin
                            s_next.tx_sh  = {1'b0, s_reg.tx_sh[7:1]};
                            s_next.tx_bit = s_reg.tx_bit + 3'h1;
                            if (s_reg.tx_bit != 3'h7) begin
                                s_next.txd = s_reg.tx_sh[1];
                            end else if (s_reg.cfg_par) begin
                                s_next.tx_st = UWFC_TX_PAR;
                                s_next.txd   = s_reg.tx_par;
                            end else begin
                                s_next.tx_st = UWFC_TX_STOP;
                                s_next.txd   = 1'b1;
                            end
                        end
                        UWFC_TX_PAR: begin
                            s_next.tx_st = UWFC_TX_STOP;
                            s_next.txd   = 1'b1;
                        end
                        default: begin
                            // One stop bit; CTS is not looked at mid-frame
                            s_next.tx_st = UWFC_TX_IDLE;
                            s_next.txd   = 1'b1;
                        end
                    endcase
                end
            end
        endcase

        // Receiver, sampling mid-bit
        case (s_reg.rx_st)
            UWFC_RX_IDLE: begin
                if (!s_reg.rxd_s2) begin
                    s_next.rx_st  = UWFC_RX_START;
                    s_next.rx_cnt = {1'b0, s_reg.cfg_div[15:1]};
                    s_next.rx_bit = 3'h0;
                end
            end
            default: begin
                if (s_reg.rx_cnt != 16'h0000) begin
                    s_next.rx_cnt = s_reg.rx_cnt - 16'h0001;
                end else begin
                    s_next.rx_cnt = s_reg.cfg_div - 16'h0001;
                    case (s_reg.rx_st)
                        UWFC_RX_START: begin
                            // Glitch shorter than half a bit is not a start
                            s_next.rx_st = s_reg.rxd_s2 ? UWFC_RX_IDLE : UWFC_RX_DATA;
                        end
                        UWFC_RX_DATA: begin
                            s_next.rx_sh  = {s_reg.rxd_s2, s_reg.rx_sh[7:1]};
                            s_next.rx_bit = s_reg.rx_bit + 3'h1;
                            if (s_reg.rx_bit == 3'h7) begin
                                s_next.rx_st = s_reg.cfg_par ? UWFC_RX_PAR : UWFC_RX_STOP;
                            end
                        end
                        UWFC_RX_PAR: begin
                            s_next.par_err = uwfc_parity8(s_reg.rx_sh) ^ s_reg.rxd_s2;
                            s_next.rx_st   = UWFC_RX_STOP;
                        end
                        default: begin
                            s_next.frm_err = ~s_reg.rxd_s2;
                            s_next.rx_word = s_reg.rx_sh;
                            s_next.rx_push = 1'b1;
                            s_next.rx_st   = UWFC_RX_IDLE;
                        end
                    endcase
                end
            end
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            s_reg          <= '0;
            s_reg.cfg_div  <= DIV_RST;
            s_reg.cfg_par  <= PAR_EN_RST;
            s_reg.cfg_flow <= FLOW_EN_RST;
            s_reg.cts_s1   <= 1'b1;
            s_reg.cts_s2   <= 1'b1;
            s_reg.rxd_s1   <= 1'b1;
            s_reg.rxd_s2   <= 1'b1;
            s_reg.txd      <= 1'b1;
            s_reg.rts_n    <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    // Two entries; RTS turns off in sleep or once both are full, so no entry is left for a word still in flight
    uwfc_buf2 #(
        .W     (DATA_BITS),
        .DEPTH (BUF_DEPTH)
    ) u_rx_buf (
        .i_clk_sys   (i_clk_sys),
        .i_reset_n   (i_reset_n),
        .i_in_data   (s_reg.rx_word),
        .i_in_valid  (s_reg.rx_push),
        .o_in_ready  (buf_in_ready),
        .o_out_data  (o_rx_data),
        .o_out_valid (o_rx_valid),
        .i_out_ready (i_rx_ready)
    );

    assign o_tx_ready   = tx_ready;
    assign o_tx_busy    = (s_reg.tx_st != UWFC_TX_IDLE);
    assign o_txd        = s_reg.txd;
    assign o_rts_n      = s_reg.rts_n;
    assign o_rx_par_err = s_reg.par_err;
    assign o_rx_frm_err = s_reg.frm_err;
    assign o_rx_overrun = s_reg.ovr;

    AST_DIV_FLOOR: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        s_reg.cfg_div >= DIV_MIN)
        else $error("baud divisor below the 1 Mbps limit");

    AST_NOFLOW_READY: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        (!s_reg.cfg_flow && s_reg.tx_st == UWFC_TX_IDLE) |-> o_tx_ready)
        else $error("transmitter idle without handshake but not ready");

    AST_RTS_OFF: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        (i_sleep || !buf_in_ready) |=> o_rts_n)
        else $error("RTS active while data cannot be accepted");

    AST_STOP_HIGH: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        (s_reg.tx_st == UWFC_TX_STOP) |-> o_txd)
        else $error("stop bit not high");

    AST_RESET_8N1: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        !s_reg.cfg_seen |-> (!s_reg.cfg_par && !s_reg.cfg_flow && s_reg.cfg_div == DIV_RST))
        else $error("format left 8N1 before configuration");

    AST_LSB_FIRST: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        (s_reg.tx_st == UWFC_TX_START && s_reg.tx_cnt == 16'h0000)
        |=> (s_reg.tx_st == UWFC_TX_DATA && o_txd == $past(s_reg.tx_sh[0])))
        else $error("first data bit is not the LSB");

    AST_CTS_BLOCK: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        (s_reg.cfg_flow && s_reg.cts_s2 && s_reg.tx_st == UWFC_TX_IDLE)
        |-> (!o_tx_ready ##1 (s_reg.tx_st == UWFC_TX_IDLE && o_txd)))
        else $error("frame offered while CTS is off");

    AST_FRAME_FINISH: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        (s_reg.tx_st == UWFC_TX_DATA && s_reg.tx_cnt != 16'h0000) |=> (s_reg.tx_st == UWFC_TX_DATA))
        else $error("frame cut short mid data bit");

endmodule // uwfc_uart

// ===== sim/uwfc_peer.sv
// Peer UART model facing the serial pins of the UART with flow control.
// Assumes the bench sets div and par to match the configuration it writes.
`timescale 1ns/1ps
module uwfc_peer (
    // Clock
    input  wire logic i_clk_sys,
    // Serial pins seen from the peer
    input  wire logic i_txd,
    input  wire logic i_rts_n,
    output logic      o_rxd,
    output logic      o_cts_n
);
    int   div = int'(uwfc_pkg::DIV_RST);
    logic par = 1'b0;

    initial begin
        o_rxd   = 1'b1;
        o_cts_n = 1'b0;
    end

    // Frame toward the device; ovr ignores RTS on purpose
    // bad flips parity, or without parity sends a low stop bit
    task automatic send(input logic [7:0] d, input logic bad, input logic ovr);
        logic [10:0] f;
        int          n;
        while (i_rts_n !== 1'b0 && !ovr) @(negedge i_clk_sys);
        f = par ? {1'b1, ^d ^ bad, d, 1'b0} : {1'b1, ~bad, d, 1'b0};
        n = par ? 11 : 10;
        for (int i = 0; i < n; i++) begin
            @(negedge i_clk_sys) o_rxd = f[i];
            repeat (div - 1) @(negedge i_clk_sys);
        end
        // Line back to idle so a low stop bit is not read as a new start
        @(negedge i_clk_sys) o_rxd = 1'b1;
    endtask

    // Samples a device frame at mid-bit, LSB first
    task automatic recv(output logic [7:0] d, output logic p, output logic s);
        @(negedge i_txd);
        repeat (div / 2) @(posedge i_clk_sys);
        for (int i = 0; i < 8; i++) begin
            repeat (div) @(posedge i_clk_sys);
            d[i] = i_txd;
        end
        p = 1'b0;
        if (par) begin
            repeat (div) @(posedge i_clk_sys);
            p = i_txd;
        end
        repeat (div) @(posedge i_clk_sys);
        s = i_txd;
    endtask
endmodule // uwfc_peer

// ===== sim/uwfc_uart_tb.sv
// Self-checking bench of the UART with flow control against a peer model.
// Assumes a 50 MHz clock; inputs change on the falling edge.
`timescale 1ns/1ps
module uwfc_uart_tb;
    import uwfc_pkg::*;

    logic i_clk_sys = 1'b0;
    logic i_reset_n = 1'b0;
    logic i_cfg_wr = 1'b0, i_cfg_par_en = 1'b0, i_cfg_flow_en = 1'b0, i_sleep = 1'b0;
    logic [15:0] i_cfg_div = DIV_RST;
    logic [7:0] i_tx_data = 8'h00, o_rx_data, b0, b1, b2;
    logic i_tx_valid = 1'b0, o_tx_ready, o_tx_busy, o_rx_valid, i_rx_ready = 1'b0;
    logic o_rx_par_err, o_rx_frm_err, o_rx_overrun, o_txd, o_rts_n, rxd, cts_n;
    int fails = 0, total_checks = 0, cyc = 0, perr_cnt = 0, ovr_cnt = 0, frm_cnt = 0, lows;
    int seed = 32'h3a13ee96;

    always #10 i_clk_sys = ~i_clk_sys;

    uwfc_uart u_uwfc_uart (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_cfg_wr(i_cfg_wr),
        .i_cfg_div(i_cfg_div), .i_cfg_par_en(i_cfg_par_en), .i_cfg_flow_en(i_cfg_flow_en),
        .i_sleep(i_sleep), .i_tx_data(i_tx_data), .i_tx_valid(i_tx_valid), .o_tx_ready(o_tx_ready),
        .o_tx_busy(o_tx_busy), .o_rx_data(o_rx_data), .o_rx_valid(o_rx_valid), .i_rx_ready(i_rx_ready),
        .o_rx_par_err(o_rx_par_err), .o_rx_frm_err(o_rx_frm_err), .o_rx_overrun(o_rx_overrun),
        .o_txd(o_txd), .i_rxd(rxd), .o_rts_n(o_rts_n), .i_cts_n(cts_n));

    uwfc_peer u_uwfc_peer (.i_clk_sys(i_clk_sys), .i_txd(o_txd), .i_rts_n(o_rts_n),
        .o_rxd(rxd), .o_cts_n(cts_n));

    // Error pulses are one cycle wide, so they are counted as they pass
    always @(posedge i_clk_sys) begin
        cyc++;
        if (o_rx_par_err === 1'b1) perr_cnt++;
        if (o_rx_overrun === 1'b1) ovr_cnt++;
        if (o_rx_frm_err === 1'b1) frm_cnt++;
        if (cyc == 60000) begin
            fails++;
            results();
        end
    end

    function automatic logic [7:0] even_bit(input logic [7:0] d);
        return {7'h00, ^d};
    endfunction

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cfg(input logic [15:0] dv, input logic p, input logic f);
        @(negedge i_clk_sys);
        {i_cfg_div, i_cfg_par_en, i_cfg_flow_en, i_cfg_wr} = {dv, p, f, 1'b1};
        @(negedge i_clk_sys) i_cfg_wr = 1'b0;
        u_uwfc_peer.div = (dv < DIV_MIN) ? int'(DIV_MIN) : int'(dv);
        u_uwfc_peer.par = p;
    endtask

    // Sends one byte; mid drives CTS to that level part way through the frame
    task automatic tx(input logic [7:0] d, input logic mid);
        logic [7:0] g;
        logic p, s;
        @(negedge i_clk_sys);
        i_tx_data = d;
        i_tx_valid = 1'b1;
        fork
            begin
                do @(posedge i_clk_sys); while (o_tx_ready !== 1'b1);
                @(negedge i_clk_sys) i_tx_valid = 1'b0;
                chk({7'h00, o_tx_busy}, 8'h01);
            end
            u_uwfc_peer.recv(g, p, s);
            begin
                repeat (150) @(negedge i_clk_sys);
                u_uwfc_peer.o_cts_n = mid;
            end
        join
        chk(g, d);
        if (u_uwfc_peer.par) chk({7'h00, p}, even_bit(d));
        chk({7'h00, s}, 8'h01);
        @(negedge i_clk_sys) u_uwfc_peer.o_cts_n = 1'b0;
    endtask

    task automatic pop(input logic [7:0] e);
        while (o_rx_valid !== 1'b1) @(negedge i_clk_sys);
        chk(o_rx_data, e);
        @(negedge i_clk_sys) i_rx_ready = 1'b1;
        @(negedge i_clk_sys) i_rx_ready = 1'b0;
    endtask

    task automatic results();
        if (fails == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    initial begin
        repeat (10) @(negedge i_clk_sys);
        i_reset_n = 1'b1;
        repeat (3) @(negedge i_clk_sys);
        chk({7'h00, o_txd}, 8'h01);
        chk({7'h00, o_rts_n}, 8'h00);
        // Default 8N1 with handshake off: CTS high must not hold the frame
        u_uwfc_peer.o_cts_n = 1'b1;
        b0 = 8'($random(seed));
        tx(b0, 1'b1);
        u_uwfc_peer.par = 1'b0;
        u_uwfc_peer.send(b0 ^ 8'hFF, 1'b0, 1'b0);
        pop(b0 ^ 8'hFF);
        // Divisor below the fastest rate is clamped to it
        cfg(16'h000A, 1'b1, 1'b1);
        for (int i = 0; i < 6; i++) begin
            b0 = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($random(seed));
            tx(b0, i[0]);
            u_uwfc_peer.send(~b0, 1'b0, 1'b0);
            pop(~b0);
        end
        chk(8'(perr_cnt), 8'h00);
        // CTS off holds a new frame until it returns
        u_uwfc_peer.o_cts_n = 1'b1;
        repeat (4) @(negedge i_clk_sys);
        i_tx_data = 8'hA5;
        i_tx_valid = 1'b1;
        lows = 0;
        repeat (200) @(negedge i_clk_sys) if (o_txd !== 1'b1 || o_tx_ready !== 1'b0 || o_tx_busy !== 1'b0) lows++;
        chk(8'(lows), 8'h00);
        u_uwfc_peer.o_cts_n = 1'b0;
        tx(8'hA5, 1'b0);
        // Wrong parity is flagged
        u_uwfc_peer.send(8'h3C, 1'b1, 1'b0);
        pop(8'h3C);
        chk(8'(perr_cnt), 8'h01);
        // Full buffer turns RTS off; a forced third word overruns
        {b0, b1, b2} = {8'($random(seed)), 8'($random(seed)), 8'($random(seed))};
        u_uwfc_peer.send(b0, 1'b0, 1'b0);
        u_uwfc_peer.send(b1, 1'b0, 1'b0);
        repeat (3) @(negedge i_clk_sys);
        chk({7'h00, o_rts_n}, 8'h01);
        u_uwfc_peer.send(b2, 1'b0, 1'b1);
        repeat (4) @(negedge i_clk_sys);
        chk(8'(ovr_cnt), 8'h01);
        pop(b0);
        pop(b1);
        repeat (3) @(negedge i_clk_sys);
        chk({7'h00, o_rts_n}, 8'h00);
        // Power saving forces RTS off
        i_sleep = 1'b1;
        repeat (3) @(negedge i_clk_sys);
        chk({7'h00, o_rts_n}, 8'h01);
        i_sleep = 1'b0;
        repeat (3) @(negedge i_clk_sys);
        chk({7'h00, o_rts_n}, 8'h00);
        // No parity at the fastest rate
        cfg(16'h0032, 1'b0, 1'b0);
        tx(8'h81, 1'b0);
        u_uwfc_peer.send(8'h7E, 1'b0, 1'b0);
        pop(8'h7E);
        // Low stop bit is flagged and the word still delivered
        u_uwfc_peer.send(8'hC3, 1'b1, 1'b0);
        pop(8'hC3);
        chk(8'(frm_cnt), 8'h01);
        results();
    end
endmodule // uwfc_uart_tb
